//--- rtl/tpg_cfg.svh
`ifndef TPG_CFG_SVH
`define TPG_CFG_SVH
// Register indices (word offsets on the plain register port)
`define TPG_REG_CTRL 4'h0
`define TPG_REG_RATE_DEF 4'h1
`define TPG_REG_WIDTH_DEF 4'h2
`define TPG_REG_RATE_LOCK 4'h3
`define TPG_REG_WIDTH_LOCK 4'h4
`define TPG_REG_CABLE_DLY 4'h5
`define TPG_REG_USER_DLY 4'h6
`define TPG_REG_STATUS 4'h7
`define TPG_REG_REPORT 4'h8
// Control field positions
`define TPG_CTRL_ENA 0
`define TPG_CTRL_RATE_FREQ 1
`define TPG_CTRL_WIDTH_RATIO 2
`define TPG_CTRL_USE_LOCKED 3
`define TPG_CTRL_FREQ_LOCK 4
`define TPG_CTRL_ALIGN 5
`define TPG_CTRL_POL 6
`define TPG_CTRL_GRID_LO 7
`define TPG_CTRL_GRID_HI 8
`define TPG_CTRL_UTCV_LO 9
`define TPG_CTRL_UTCV_HI 11
`define TPG_CTRL_RST 32'h0000_0041
// Reset values of rate and width (1 s period, 100 ms width, in us)
`define TPG_RATE_RST 32'h000F_4240
`define TPG_WIDTH_RST 32'h0001_86A0
// Time constants
`define TPG_CLK_MHZ 125
`define TPG_US_PER_S 32'h000F_4240
`define TPG_PCT_FULL 32'h0000_0064
`endif

//--- rtl/tpg_pkg.sv
package tpg_pkg;
   // Output time grid
   typedef enum logic [1:0] {
      TPG_GRID_UTC = 2'h0,
      TPG_GRID_GPS = 2'h1,
      TPG_GRID_GLO = 2'h2,
      TPG_GRID_BDS = 2'h3
   } tpg_grid_t;
   // UTC variant
   typedef enum logic [2:0] {
      TPG_UTC_AUTO = 3'h0,
      TPG_UTC_US = 3'h1,
      TPG_UTC_RU = 3'h2,
      TPG_UTC_CN = 3'h3,
      TPG_UTC_EU = 3'h4
   } tpg_utc_t;
   // Pulse phase, one-hot
   typedef enum logic [2:0] {
      TPG_ST_IDLE = 3'b001,
      TPG_ST_ACTIVE = 3'b010,
      TPG_ST_REST = 3'b100
   } tpg_state_t;
endpackage

//--- rtl/tpg_time_pulse.sv
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`include "tpg_cfg.svh"
// Notes on behaviour
// - Pulses only while enable set
// - Rate read as frequency or period
// - Width read as microseconds or percent
// - Default setting unless locked mode and valid
// - Locked setting once valid time known
// - Active part set from width setting
// - Cable and user delay shift timing
// - Frequency lock uses recovered satellite tick
// - Alignment places edges on second boundaries
// - Polarity sets leading edge direction
// - Grid codes UTC GPS GLONASS BeiDou
// - Width never exceeds period
// - Only first channel drives the pin
// - Input pulse uses output time base
// - UTC grid: input pulse taken as GPS
// - Auto UTC: US, RU, CN, EU preference
// - Report once per second, names next pulse
// - UTC grid waits for conversion data
// - Alignment only while time valid, rate continues
module tpg_time_pulse
   import tpg_pkg::*;
#(
   parameter int CLK_MHZ = `TPG_CLK_MHZ,
   parameter int CNT_W = 40
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic time_valid,
   input wire logic utc_data_ok,
   input wire logic sec_tick,
   input wire logic gnss_tick_us,
   input wire logic gps_en,
   input wire logic glo_en,
   input wire logic bds_en,
   input wire logic gal_en,
   output logic first_pulse_channel,
   output logic report_strobe,
   output logic [CNT_W-1:0] report_next_edge,
   output logic [1:0] report_time_base,
   output logic [1:0] ext_input_base
);
   // Refuse parameters the 8-bit prescaler or the counters cannot serve
   if (CLK_MHZ < 1 || CLK_MHZ > 255 || CNT_W < 34) begin : g_bad_params
      $error("tpg_time_pulse: unsupported parameters");
   end

   localparam logic [CNT_W-1:0] US_PER_S = CNT_W'(`TPG_US_PER_S);
   localparam logic [CNT_W-1:0] PCT_FULL = CNT_W'(`TPG_PCT_FULL);
   localparam logic [7:0] CLK_PER_US = 8'(CLK_MHZ);

   // Software-written configuration
   logic [31:0] ctrl;
   logic [31:0] rate_def, width_def, rate_lock, width_lock;
   logic [31:0] cable_dly, user_dly;

   // Synchronised outside-domain levels and ticks
   logic [6:0] sync1, sync2;
   logic sec_prev, gtick_prev;

   // Pulse engine state
   tpg_state_t state;
   logic [CNT_W-1:0] us_cnt;    // Microseconds into current period
   logic [7:0] pre_cnt;         // Clock cycles into current microsecond
   logic [CNT_W-1:0] since_sec; // Microseconds since last pulse start (not read)
   logic pulse_start;

   // Register writes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl <= `TPG_CTRL_RST;
         rate_def <= `TPG_RATE_RST;
         width_def <= `TPG_WIDTH_RST;
         rate_lock <= `TPG_RATE_RST;
         width_lock <= `TPG_WIDTH_RST;
         cable_dly <= 32'h0;
         user_dly <= 32'h0;
      end else if (reg_wr) begin
         unique case (reg_addr)
            `TPG_REG_CTRL: ctrl <= reg_wdata;
            `TPG_REG_RATE_DEF: rate_def <= reg_wdata;
            `TPG_REG_WIDTH_DEF: width_def <= reg_wdata;
            `TPG_REG_RATE_LOCK: rate_lock <= reg_wdata;
            `TPG_REG_WIDTH_LOCK: width_lock <= reg_wdata;
            `TPG_REG_CABLE_DLY: cable_dly <= reg_wdata;
            `TPG_REG_USER_DLY: user_dly <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Two-stage synchronisers for pin inputs
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1 <= 7'h00;
         sync2 <= 7'h00;
      end else begin
         sync1 <= {gal_en, bds_en, glo_en, gps_en, gnss_tick_us, sec_tick, time_valid};
         sync2 <= sync1;
      end
   end

   wire s_valid = sync2[0];
   wire s_sec = sync2[1];
   wire s_gtick = sync2[2];

   // Edge detect on synchronised ticks
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sec_prev <= 1'b0;
         gtick_prev <= 1'b0;
      end else begin
         sec_prev <= s_sec;
         gtick_prev <= s_gtick;
      end
   end

   wire sec_rise = s_sec & ~sec_prev;
   wire gtick_rise = s_gtick & ~gtick_prev;

   // Decoded configuration
   wire ena = ctrl[`TPG_CTRL_ENA];
   wire rate_is_freq = ctrl[`TPG_CTRL_RATE_FREQ];
   wire width_is_ratio = ctrl[`TPG_CTRL_WIDTH_RATIO];
   wire use_locked = ctrl[`TPG_CTRL_USE_LOCKED];
   wire freq_lock = ctrl[`TPG_CTRL_FREQ_LOCK];
   wire align = ctrl[`TPG_CTRL_ALIGN];
   wire pol_rise = ctrl[`TPG_CTRL_POL];
   tpg_grid_t grid;
   assign grid = tpg_grid_t'(ctrl[`TPG_CTRL_GRID_HI:`TPG_CTRL_GRID_LO]);

   // Select setting by lock state
   wire locked_sel = use_locked & s_valid;
   wire [31:0] rate_sel = locked_sel ? rate_lock : rate_def;
   wire [31:0] width_sel = locked_sel ? width_lock : width_def;

   // Period in microseconds, from frequency or period
   logic [CNT_W-1:0] period_us;
   always_comb begin
      if (rate_is_freq) begin
         // Frequency in Hz; zero frequency treated as one second
         period_us = (rate_sel == 32'h0) ? US_PER_S : US_PER_S / CNT_W'(rate_sel);
      end else begin
         period_us = CNT_W'(rate_sel);
      end
      if (period_us == '0) begin
         period_us = CNT_W'(1);
      end
   end

   // Active width in microseconds, clipped to period
   logic [CNT_W-1:0] width_raw, width_us;
   // Ratio above full scale reads as always on; keeps the product in range
   wire [31:0] ratio_c = (width_sel > `TPG_PCT_FULL) ? `TPG_PCT_FULL : width_sel;
   always_comb begin
      if (width_is_ratio) begin
         width_raw = (period_us * CNT_W'(ratio_c)) / PCT_FULL;
      end else begin
         width_raw = CNT_W'(width_sel);
      end
      width_us = (width_raw > period_us) ? period_us : width_raw;
   end

   // Pulse output gated: enable, and UTC grid waits for conversion data
   logic sync1_utc_ok, sync2_utc_ok;
   wire utc_hold = (grid == TPG_GRID_UTC) & ~sync2_utc_ok;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_utc_ok <= 1'b0;
         sync2_utc_ok <= 1'b0;
      end else begin
         sync1_utc_ok <= utc_data_ok;
         sync2_utc_ok <= sync1_utc_ok;
      end
   end
   wire run = ena & ~utc_hold;

   // Microsecond tick: recovered satellite tick or local divider
   wire local_us = (pre_cnt == CLK_PER_US - 8'h01);
   wire us_tick = freq_lock ? gtick_rise : local_us;

   // Local microsecond prescaler
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pre_cnt <= 8'h00;
      end else if (local_us) begin
         pre_cnt <= 8'h00;
      end else begin
         pre_cnt <= pre_cnt + 8'h01;
      end
   end

   // Total delay shifts the pulse earlier against the second boundary
   wire [CNT_W-1:0] dly_us = CNT_W'(cable_dly) + CNT_W'(user_dly);
   wire [CNT_W-1:0] dly_mod = (dly_us >= period_us) ? (dly_us % period_us) : dly_us;
   wire [CNT_W-1:0] align_pos = dly_mod;
   wire do_align = align & s_valid & sec_rise;

   // Period counter: free-runs always, realigned on second tick while time valid
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         us_cnt <= '0;
      end else if (do_align) begin
         us_cnt <= align_pos;
      end else if (us_tick) begin
         us_cnt <= (us_cnt + CNT_W'(1) >= period_us) ? '0 : us_cnt + CNT_W'(1);
      end
   end

   assign pulse_start = us_tick & (us_cnt + CNT_W'(1) >= period_us);

   // Pulse phase state machine
   tpg_state_t next_state;
   always_comb begin
      next_state = state;
      unique case (state)
         TPG_ST_IDLE: if (run) next_state = TPG_ST_REST;
         TPG_ST_ACTIVE: begin
            if (!run) next_state = TPG_ST_IDLE;
            else if (us_cnt >= width_us) next_state = TPG_ST_REST;
         end
         TPG_ST_REST: begin
            if (!run) next_state = TPG_ST_IDLE;
            else if (us_cnt < width_us) next_state = TPG_ST_ACTIVE;
         end
         default: next_state = TPG_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= TPG_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Pin drive: polarity picks idle level, only channel one exists
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         first_pulse_channel <= 1'b0;
      end else begin
         first_pulse_channel <= (next_state == TPG_ST_ACTIVE) ? pol_rise : ~pol_rise;
      end
   end

   // Automatic UTC variant choice
   tpg_utc_t utc_cfg, utc_eff;
   assign utc_cfg = tpg_utc_t'(ctrl[`TPG_CTRL_UTCV_HI:`TPG_CTRL_UTCV_LO]);
   always_comb begin
      utc_eff = utc_cfg;
      if (utc_cfg == TPG_UTC_AUTO) begin
         if (sync2[3]) utc_eff = TPG_UTC_US;
         else if (sync2[4]) utc_eff = TPG_UTC_RU;
         else if (sync2[5]) utc_eff = TPG_UTC_CN;
         else if (sync2[6]) utc_eff = TPG_UTC_EU;
         else utc_eff = TPG_UTC_AUTO;
      end
   end

   // Time base for external input and report
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ext_input_base <= 2'h0;
         report_time_base <= 2'h0;
      end else begin
         ext_input_base <= (grid == TPG_GRID_UTC) ? TPG_GRID_GPS : grid;
         report_time_base <= grid;
      end
   end

   // Microseconds since last pulse start
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         since_sec <= '0;
      end else if (pulse_start) begin
         since_sec <= '0;
      end else if (us_tick) begin
         since_sec <= since_sec + CNT_W'(1);
      end
   end

   // One-second report counter on the local microsecond tick
   logic [CNT_W-1:0] rpt_cnt;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rpt_cnt <= '0;
      end else if (local_us) begin
         rpt_cnt <= (rpt_cnt == US_PER_S - CNT_W'(1)) ? '0 : rpt_cnt + CNT_W'(1);
      end
   end

   // Report: fixed 1 Hz, always names the coming pulse
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         report_strobe <= 1'b0;
         report_next_edge <= '0;
      end else begin
         report_strobe <= local_us & (rpt_cnt == US_PER_S - CNT_W'(1));
         if (local_us & (rpt_cnt == US_PER_S - CNT_W'(1))) begin
            report_next_edge <= period_us - us_cnt;
         end
      end
   end

   // Register reads, one cycle later; unmapped reads zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 32'h0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `TPG_REG_CTRL: reg_rdata <= ctrl;
            `TPG_REG_RATE_DEF: reg_rdata <= rate_def;
            `TPG_REG_WIDTH_DEF: reg_rdata <= width_def;
            `TPG_REG_RATE_LOCK: reg_rdata <= rate_lock;
            `TPG_REG_WIDTH_LOCK: reg_rdata <= width_lock;
            `TPG_REG_CABLE_DLY: reg_rdata <= cable_dly;
            `TPG_REG_USER_DLY: reg_rdata <= user_dly;
            `TPG_REG_STATUS: reg_rdata <= {24'h0, utc_eff, locked_sel, utc_hold, state == TPG_ST_ACTIVE, run, s_valid};
            `TPG_REG_REPORT: reg_rdata <= 32'(report_next_edge);
            default: reg_rdata <= 32'h0;
         endcase
      end else begin
         reg_rdata <= 32'h0;
      end
   end

   // Assertions
   a_width_clip: assert property (@(posedge clk) disable iff (!arst_n)
      width_us <= period_us) else $error("width exceeds period");
   a_disable_idle: assert property (@(posedge clk) disable iff (!arst_n)
      !run |=> state == TPG_ST_IDLE) else $error("pulse while disabled");
   a_pol_idle: assert property (@(posedge clk) disable iff (!arst_n)
      state == TPG_ST_IDLE && $stable(pol_rise) |=> first_pulse_channel == ~pol_rise)
      else $error("idle level wrong");
   a_locked_select: assert property (@(posedge clk) disable iff (!arst_n)
      use_locked && s_valid |-> rate_sel == rate_lock) else $error("locked set unused");
   a_default_select: assert property (@(posedge clk) disable iff (!arst_n)
      !(use_locked && s_valid) |-> width_sel == width_def) else $error("default unused");
   a_utc_hold: assert property (@(posedge clk) disable iff (!arst_n)
      grid == TPG_GRID_UTC && !sync2_utc_ok |-> !run) else $error("utc not held");
   a_ext_base: assert property (@(posedge clk) disable iff (!arst_n)
      grid == TPG_GRID_UTC && $stable(grid) |=> ext_input_base == TPG_GRID_GPS)
      else $error("input base wrong");
   a_report_pulse: assert property (@(posedge clk) disable iff (!arst_n)
      report_strobe |=> !report_strobe) else $error("report not one cycle");
   a_ratio_width: assert property (@(posedge clk) disable iff (!arst_n)
      width_is_ratio && width_sel == `TPG_PCT_FULL |-> width_us == period_us)
      else $error("ratio 100 not full");
endmodule

//--- testbench/tpg_pulse_watch.sv
`timescale 1ns/1ps
// Far-side equipment: times each pulse from one leading edge to the next
module tpg_pulse_watch (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic pin,
   input wire logic pol,
   output logic meas_valid,
   output logic [31:0] meas_width,
   output logic [31:0] meas_period
);
   logic prev; // Pin level one cycle ago
   logic have; // A leading edge was already seen
   logic [31:0] cnt; // Cycles since the last leading edge
   logic [31:0] act; // Active cycles since the last leading edge
   logic lead; // Leading edge in this cycle
   assign lead = (pin == pol) && (prev != pol);
   // Report the previous pulse at every leading edge after the first
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prev <= 1'b0;
         have <= 1'b0;
         cnt <= 32'h0;
         act <= 32'h0;
         meas_valid <= 1'b0;
         meas_width <= 32'h0;
         meas_period <= 32'h0;
      end else begin
         prev <= pin;
         have <= have | lead;
         cnt <= lead ? 32'h1 : cnt + 32'h1;
         act <= lead ? 32'h1 : act + {31'h0, pin == pol};
         meas_valid <= lead && have;
         if (lead) begin
            meas_width <= act;
            meas_period <= cnt;
         end
      end
   end
endmodule

//--- testbench/gnss_time_pulse_generator_tb_top.sv
`timescale 1ns/1ps
`include "tpg_cfg.svh"
module gnss_time_pulse_generator_tb_top;
   import tpg_pkg::*;
   typedef struct {logic [31:0] w; logic [31:0] p; int u;} tpg_exp_t;
   typedef struct {logic [31:0] d; logic [31:0] m;} tpg_rd_t;
   logic clk = 1'b0, arst_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
   logic [31:0] reg_rdata;
   logic time_valid = 1'b0, utc_data_ok = 1'b1, sec_tick = 1'b0, gnss_tick_us = 1'b0;
   logic gps_en = 1'b1, glo_en = 1'b0, bds_en = 1'b0, gal_en = 1'b0;
   logic pin, report_strobe, pol_r = 1'b1, meas_valid;
   logic [39:0] report_next_edge;
   logic [1:0] report_time_base, ext_input_base;
   logic [31:0] meas_width, meas_period;
   int fail_count = 0, samples_checked = 0, cyc = 0, tick_half = 62, cnt, i, rpt_seen = 0;
   int seed = 32'hf4a504d1;
   logic [31:0] w;
   tpg_exp_t pq[$]; // Expected pulses, oldest first
   tpg_rd_t rq[$]; // Expected read data, oldest first
   // Design under test
   tpg_time_pulse dut_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .time_valid(time_valid), .utc_data_ok(utc_data_ok), .sec_tick(sec_tick),
      .gnss_tick_us(gnss_tick_us), .gps_en(gps_en), .glo_en(glo_en), .bds_en(bds_en),
      .gal_en(gal_en), .first_pulse_channel(pin), .report_strobe(report_strobe),
      .report_next_edge(report_next_edge), .report_time_base(report_time_base),
      .ext_input_base(ext_input_base));
   // Equipment timing the pulse pin
   tpg_pulse_watch watch_u (.clk(clk), .arst_n(arst_n), .pin(pin), .pol(pol_r),
      .meas_valid(meas_valid), .meas_width(meas_width), .meas_period(meas_period));
   // Clock at 125 MHz
   initial begin
      forever #4 clk = ~clk;
   end
   // Recovered satellite microsecond tick, rate set by tick_half
   initial begin
      forever begin
         repeat (tick_half) @(posedge clk);
         gnss_tick_us <= ~gnss_tick_us;
      end
   end
   // Compare one value and count it
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Print counts and verdict, then end the run
   task automatic stop_test();
      $display("Checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // One-cycle register write
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // One-cycle register read, expectation noted for the watcher
   task automatic reg_read(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
      @(posedge clk);
      rq.push_back('{d: d, m: m});
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask
   // Program a setting, let it settle, then expect two pulses
   task automatic pulses(input logic [31:0] c, input logic [31:0] ew, input logic [31:0] ep,
                         input int u);
      reg_write(`TPG_REG_CTRL, c);
      pol_r <= c[`TPG_CTRL_POL];
      repeat (3000) @(posedge clk);
      pq.push_back('{w: ew, p: ep, u: u});
      pq.push_back('{w: ew, p: ep, u: u});
      while (pq.size() > 0) @(posedge clk);
   endtask
   // Count cycles with the pin at a level
   task automatic count_level(input logic lvl, output int n);
      n = 0;
      // Let the previous setting drain before counting
      repeat (200) @(posedge clk);
      repeat (3000) begin
         @(posedge clk);
         if (pin === lvl) n++;
      end
   endtask
   // Watcher: read data in the cycle after the strobe, pulses when measured
   always @(posedge clk) begin
      tpg_rd_t r;
      tpg_exp_t e;
      rd_d <= reg_rd;
      if (report_strobe === 1'b1) rpt_seen++;
      if (rd_d === 1'b1 && rq.size() > 0) begin
         r = rq.pop_front();
         check(reg_rdata & r.m, r.d);
      end
      if (meas_valid === 1'b1 && pq.size() > 0) begin
         e = pq.pop_front();
         check((meas_width + e.u / 2) / e.u, e.w);
         check((meas_period + e.u / 2) / e.u, e.p);
      end
   end
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 95000) begin
         fail_count++;
         stop_test();
      end
   end
   // Main sequence; all settings timed by the watcher keep both phases well above 50 ns
   initial begin
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      reg_read(`TPG_REG_CTRL, `TPG_CTRL_RST, 32'hFFFFFFFF);
      reg_read(`TPG_REG_RATE_DEF, `TPG_RATE_RST, 32'hFFFFFFFF);
      reg_read(`TPG_REG_WIDTH_DEF, `TPG_WIDTH_RST, 32'hFFFFFFFF);
      reg_read(4'hF, 32'h0, 32'hFFFFFFFF);
      reg_write(`TPG_REG_RATE_DEF, 32'h0000_000A);
      reg_write(`TPG_REG_WIDTH_DEF, 32'h0000_0004);
      reg_read(`TPG_REG_WIDTH_DEF, 32'h0000_0004, 32'hFFFFFFFF);
      reg_write(`TPG_REG_CTRL, 32'h0000_00C0);
      count_level(1'b1, cnt);
      check(cnt, 0);
      w = 32'h1 + ($unsigned($random(seed)) % 9);
      reg_write(`TPG_REG_WIDTH_DEF, w);
      pulses(32'h0000_00C1, w, 32'hA, 125);
      reg_write(`TPG_REG_WIDTH_DEF, 32'h0000_0004);
      pulses(32'h0000_0081, 32'h4, 32'hA, 125);
      reg_write(`TPG_REG_RATE_DEF, 32'h0001_86A0);
      reg_write(`TPG_REG_WIDTH_DEF, 32'h0000_001E);
      pulses(32'h0000_00C7, 32'h3, 32'hA, 125);
      reg_write(`TPG_REG_RATE_DEF, 32'h0000_000A);
      reg_write(`TPG_REG_WIDTH_DEF, 32'h0000_000F);
      reg_write(`TPG_REG_CTRL, 32'h0000_00C1);
      count_level(1'b0, cnt);
      check(cnt, 0);
      reg_write(`TPG_REG_WIDTH_DEF, 32'h0000_0004);
      reg_write(`TPG_REG_RATE_LOCK, 32'h0000_0005);
      reg_write(`TPG_REG_WIDTH_LOCK, 32'h0000_0001);
      time_valid <= 1'b1;
      pulses(32'h0000_00C9, 32'h1, 32'h5, 125);
      time_valid <= 1'b0;
      pulses(32'h0000_00C9, 32'h4, 32'hA, 125);
      tick_half = 50;
      pulses(32'h0000_00D1, 32'h4, 32'hA, 100);
      tick_half = 62;
      // Second boundary realigns; 3 us of delay brings the pulse 3 us early
      reg_write(`TPG_REG_CABLE_DLY, 32'h0000_0002);
      reg_write(`TPG_REG_USER_DLY, 32'h0000_0001);
      time_valid <= 1'b1;
      reg_write(`TPG_REG_CTRL, 32'h0000_00E1);
      repeat (200) @(posedge clk);
      sec_tick <= 1'b1;
      cnt = 0;
      while (cnt < 8 || pin !== 1'b0) begin
         @(posedge clk);
         cnt++;
      end
      while (pin !== 1'b1) begin
         @(posedge clk);
         cnt++;
      end
      check({31'h0, cnt > 740 && cnt < 890}, 32'h1);
      sec_tick <= 1'b0;
      time_valid <= 1'b0;
      utc_data_ok <= 1'b0;
      reg_write(`TPG_REG_CTRL, 32'h0000_0041);
      count_level(1'b1, cnt);
      check(cnt, 0);
      utc_data_ok <= 1'b1;
      pulses(32'h0000_0041, 32'h4, 32'hA, 125);
      for (i = 0; i < 4; i++) begin
         reg_write(`TPG_REG_CTRL, 32'h0000_0041 | (i << 7));
         repeat (10) @(posedge clk);
         check({30'h0, ext_input_base}, (i == 0) ? 32'h1 : i);
         check({30'h0, report_time_base}, i);
      end
      reg_write(`TPG_REG_CTRL, 32'h0000_0041);
      for (i = 0; i < 4; i++) begin
         {gps_en, glo_en, bds_en, gal_en} <= 4'hF >> i;
         repeat (10) @(posedge clk);
         reg_read(`TPG_REG_STATUS, (i + 1) << 5, 32'h0000_00E0);
      end
      repeat (5) @(posedge clk);
      // The run is far shorter than one second, so no report may appear
      check(rpt_seen, 0);
      stop_test();
   end
endmodule
